/* logic/dss_pkg.sv */
package dss_pkg;
   // clock and timing
   localparam int CLK_NS = 100;
   localparam int CYCLE_CNT = 40002;       // full measurement cycle, counts
   localparam int SIG_CNT = 10000;         // fixed signal integrate, counts
   localparam int AZ_START_CNT = 10001;    // auto-zero after a hold start
   localparam int SCAN_CNT = 200;          // digit drive period, counts
   localparam int STROBE_AT = 100;         // down-count value where strobe starts
   localparam int DIGITS = 5;
   localparam int STROBE_NS = 5000;
   localparam int STROBE_CYC = (STROBE_NS / CLK_NS < 1) ? 1 : STROBE_NS / CLK_NS;
   localparam int HOLD_PULSE_NS = 300;
   localparam int HOLD_PULSE_CYC = (HOLD_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [19:0] OVR_BCD = 20'h2_0000;   // 20000 counts in bcd
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [1:0] {
      PH_SIG,
      PH_REF,
      PH_AZ,
      PH_HOLD
   } dss_phase_t;

   typedef struct packed {
      logic            positive;
      logic            overRange;
      logic [4:0][3:0] digits;
   } dss_reading_t;
endpackage

/* logic/dss_fifo.sv */
`timescale 1ns/10ps
module dss_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             refClk,
   input  wire logic             arstN,
   // filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0]      count_q, count_d;
   logic             doPush, doPop;

   // full and empty follow the occupancy count directly
   assign inReady  = count_q != (AW+1)'(DEPTH);
   assign outValid = count_q != '0;
   assign outData  = mem[rdPtr_q];
   assign doPush   = inValid & inReady;
   assign doPop    = outValid & outReady;

   always_comb begin
      wrPtr_d = doPush ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_d = doPop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
      count_d = count_q;
      if (doPush & ~doPop) begin
         count_d = (AW+1)'(count_q + 1'b1);
      end else if (doPop & ~doPush) begin
         count_d = (AW+1)'(count_q - 1'b1);
      end
   end

   always_ff @(posedge refClk or negedge arstN) begin
      if (!arstN) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end

   // storage needs no reset, valid is carried by the count
   always_ff @(posedge refClk) begin
      if (doPush) begin
         mem[wrPtr_q] <= inData;
      end
   end
endmodule

/* logic/dss_sequencer.sv */
`timescale 1ns/10ps
// Summary of operation
// - busy goes high at signal integrate, low after crossing or cycle end
// - result latches load in that first clock and then stay frozen
// - hold high: free-run, one cycle every 40,002 clocks
// - hold low: finish the cycle, then keep presenting that reading
// - while holding, hold pulse of at least four clocks (400 ns) starts cycle with auto-zero
// - hold pulse ending before the cycle completes is ignored
// - first strobe 101 counts after cycle end marks holding and ready
// - grounded blanking input blanks the digits; open shows them
// - sign and decimal points ignore blanking, flash above 19999 counts while free-running (blink is frozen while holding)
// - any of four decimal points lit when its select is low
// - signal integrate 10000 counts, then clear counters and integrate reference
// - reference integrate counts until zero crossing; count is the reading
// - after crossing, auto-zero integrator and comparator until next reading
// - hold low keeps the counters from restarting a conversion
// - overrange flag set at conversion-done, cleared at next reference start
// - digits scan msd to lsd, 200 clocks each; overrange blanks them
// - five low strobes per new reading, each starting mid-digit, first at 101, 5 us
// - polarity high for positive, valid from reference start to next
module dss_sequencer #(
   parameter int CYCLE_CNT    = dss_pkg::CYCLE_CNT,
   parameter int SIG_CNT      = dss_pkg::SIG_CNT,
   parameter int AZ_START_CNT = dss_pkg::AZ_START_CNT
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // analog front end, asynchronous
   input  wire logic        zeroCross,
   input  wire logic        signalPositive,
   // control pins, asynchronous
   input  wire logic        holdRun,
   input  wire logic        blankingN,
   input  wire logic [3:0]  decimalPointSelN,
   // analog switch controls
   output logic             signal_integrate_phase,
   output logic             reference_integrate_phase,
   output logic             auto_zero_phase,
   output logic             refNegative,
   // result and display
   output logic             convBusy,
   output logic             over_range_flag,
   output logic             polarity,
   output logic             signLit,
   output logic [3:0]       decimalPointLit,
   output logic [4:0]       digit_drive,
   output logic [3:0]       bcdDigit,
   output logic             strobeN,
   // reading stream
   output logic             readingValid,
   input  wire logic        readingReady,
   output dss_pkg::dss_reading_t readingData
);
   localparam logic [15:0] CYC_LAST = 16'(CYCLE_CNT - 1);
   localparam logic [15:0] SIG_LAST = 16'(SIG_CNT - 1);
   localparam logic [15:0] AZ_FROM  = 16'(CYCLE_CNT - AZ_START_CNT);
   localparam logic [7:0]  SCAN_TOP = 8'(dss_pkg::SCAN_CNT - 1);
   localparam logic [7:0]  SCAN_FST = 8'(dss_pkg::SCAN_CNT);
   localparam logic [7:0]  STB_AT   = 8'(dss_pkg::STROBE_AT);
   localparam logic [5:0]  STB_LAST = 6'(dss_pkg::STROBE_CYC - 1);
   localparam logic [1:0]  HOLD_MIN = 2'(dss_pkg::HOLD_PULSE_CYC);

   // two-flop synchronisers for every pin input
   logic [7:0] pinRaw, sync1_q, sync2_q;
   assign pinRaw = {decimalPointSelN, blankingN, holdRun, signalPositive, zeroCross};
   generate
      for (genvar i = 0; i < 8; i++) begin : g_sync
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               sync1_q[i] <= 1'b1;
               sync2_q[i] <= 1'b1;
            end else begin
               sync1_q[i] <= pinRaw[i];
               sync2_q[i] <= sync1_q[i];
            end
         end
      end
   endgenerate

   logic       crossS, posS, holdS, blankNS;
   logic [3:0] dpSelNS;
   assign {dpSelNS, blankNS, holdS, posS, crossS} = sync2_q;

   // sequencing state
   dss_pkg::dss_phase_t  phase_q, phase_d;
   logic [15:0]          cyc_q, cyc_d;
   logic [4:0][3:0]      cnt_q, cnt_d, cntInc;
   dss_pkg::dss_reading_t rd_q, rd_d;
   logic startPend_q, startPend_d, ovrPend_q, ovrPend_d;
   logic armed_q, armed_d, pol_q, pol_d, ovr_q, ovr_d, busy_q, busy_d;
   logic [1:0] holdHi_q, holdHi_d;
   logic       push_q, push_d, blink_q, blink_d;
   // display state
   logic [2:0] dig_q, dig_d, stbLeft_q, stbLeft_d;
   logic [7:0] scan_q, scan_d;
   logic [5:0] stbW_q, stbW_d;
   logic       stbN_q, stbN_d, ovrBlank_q, ovrBlank_d;
   logic [4:0] drive_q, drive_d;
   logic [3:0] bcd_q, bcd_d, dpLit_q, dpLit_d;
   logic       signLit_q, signLit_d, flashOff;
   logic       fifoReady, fifoValid;
   logic       cycEnd, fullEnd, refStart;
   dss_pkg::dss_reading_t fifoData;

   // bcd ripple increment, one carry stage per decade
   logic [5:0] carry;
   assign carry[0] = 1'b1;
   generate
      for (genvar d = 0; d < 5; d++) begin : g_bcd
         assign cntInc[d]  = !carry[d] ? cnt_q[d] :
                             (cnt_q[d] == 4'h9) ? 4'h0 : 4'(cnt_q[d] + 4'h1);
         assign carry[d+1] = carry[d] & (cnt_q[d] == 4'h9);
      end
   endgenerate

   assign cycEnd   = (cyc_q == CYC_LAST) && (phase_q != dss_pkg::PH_HOLD);
   assign fullEnd  = cycEnd & ~startPend_q;  // a hold-start auto-zero is no reading
   assign refStart = (phase_q == dss_pkg::PH_SIG) && (cyc_q == SIG_LAST);

   // conversion sequencing
   always_comb begin
      phase_d     = phase_q;
      cyc_d       = 16'(cyc_q + 16'h0001);
      cnt_d       = cnt_q;
      rd_d        = rd_q;
      startPend_d = startPend_q;
      ovrPend_d   = ovrPend_q;
      armed_d     = armed_q;
      pol_d       = pol_q;
      ovr_d       = ovr_q;
      busy_d      = busy_q;
      holdHi_d    = holdS ? ((holdHi_q == HOLD_MIN) ? holdHi_q : 2'(holdHi_q + 2'h1)) : 2'h0;
      push_d      = 1'b0;
      blink_d     = blink_q;
      unique case (phase_q)
         dss_pkg::PH_SIG: begin
            if (refStart) begin
               phase_d = dss_pkg::PH_REF;
               cnt_d   = '0;
               ovr_d   = 1'b0;
               pol_d   = posS;
            end
         end
         dss_pkg::PH_REF: begin
            cnt_d = cntInc;
            if (crossS) begin
               // first clock after crossing loads the latch once
               phase_d          = dss_pkg::PH_AZ;
               rd_d.digits      = cnt_q;
               rd_d.positive    = pol_q;
               rd_d.overRange   = 1'b0;
               busy_d           = 1'b0;
               push_d           = 1'b1;
            end else if (cnt_q == dss_pkg::OVR_BCD) begin
               phase_d   = dss_pkg::PH_AZ;
               cnt_d     = cnt_q;       // count stops at full scale
               ovrPend_d = 1'b1;
            end
         end
         dss_pkg::PH_AZ: begin
         end
         dss_pkg::PH_HOLD: begin
            cyc_d = cyc_q;
            if (!holdS) begin
               armed_d = 1'b1;
            end else if (armed_q && holdHi_q == HOLD_MIN) begin
               phase_d     = dss_pkg::PH_AZ;
               cyc_d       = AZ_FROM;
               startPend_d = 1'b1;
               armed_d     = 1'b0;
            end
         end
      endcase
      if (cycEnd) begin
         blink_d = ~blink_q;
         if (ovrPend_q) begin
            // overrange reading finishes only at the end of measurement
            ovrPend_d      = 1'b0;
            rd_d.digits    = cnt_q;
            rd_d.positive  = pol_q;
            rd_d.overRange = 1'b1;
            busy_d         = 1'b0;
            ovr_d          = 1'b1;
            push_d         = 1'b1;
         end
         // stream back-pressure stalls the next start like hold does
         if ((holdS | startPend_q) & fifoReady) begin
            phase_d     = dss_pkg::PH_SIG;
            cyc_d       = '0;
            busy_d      = 1'b1;
            startPend_d = 1'b0;
         end else begin
            phase_d = dss_pkg::PH_HOLD;
            cyc_d   = cyc_q;
            armed_d = ~holdS;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q     <= dss_pkg::PH_AZ;
         cyc_q       <= '0;
         cnt_q       <= '0;
         rd_q        <= '0;
         startPend_q <= 1'b0;
         ovrPend_q   <= 1'b0;
         armed_q     <= 1'b0;
         pol_q       <= 1'b1;
         ovr_q       <= 1'b0;
         busy_q      <= 1'b1;
         holdHi_q    <= '0;
         push_q      <= 1'b0;
         blink_q     <= 1'b0;
      end else begin
         phase_q     <= phase_d;
         cyc_q       <= cyc_d;
         cnt_q       <= cnt_d;
         rd_q        <= rd_d;
         startPend_q <= startPend_d;
         ovrPend_q   <= ovrPend_d;
         armed_q     <= armed_d;
         pol_q       <= pol_d;
         ovr_q       <= ovr_d;
         busy_q      <= busy_d;
         holdHi_q    <= holdHi_d;
         push_q      <= push_d;
         blink_q     <= blink_d;
      end
   end

   assign flashOff = rd_q.overRange & blink_q;

   // digit scan, strobes and display gating
   always_comb begin
      dig_d      = dig_q;
      scan_d     = 8'(scan_q - 8'h01);
      stbLeft_d  = stbLeft_q;
      stbW_d     = stbW_q;
      stbN_d     = stbN_q;
      ovrBlank_d = ovrBlank_q;
      if (fullEnd) begin
         dig_d     = 3'd4;              // msd held 201 counts
         scan_d    = SCAN_FST;
         stbLeft_d = 3'(dss_pkg::DIGITS);
      end else if (refStart) begin
         dig_d      = 3'd4;
         scan_d     = SCAN_TOP;
         ovrBlank_d = 1'b0;
      end else if (scan_q == '0) begin
         scan_d = SCAN_TOP;
         dig_d  = (dig_q == '0) ? 3'd4 : 3'(dig_q - 3'd1);
      end
      if (scan_q == STB_AT && stbLeft_q != '0 && !fullEnd) begin
         // mid-period strobe keeps clear of bcd changes
         stbN_d    = 1'b0;
         stbW_d    = STB_LAST;
         stbLeft_d = 3'(stbLeft_q - 3'd1);
      end else if (!stbN_q) begin
         stbW_d = 6'(stbW_q - 6'h01);
         if (stbW_q == '0) begin
            stbN_d = 1'b1;
            if (stbLeft_q == '0 && rd_q.overRange) begin
               ovrBlank_d = 1'b1;
            end
         end
      end
      for (int i = 0; i < 5; i++) begin
         drive_d[i] = (dig_d == 3'(i)) & blankNS & ~ovrBlank_d;
      end
      bcd_d = rd_q.digits[dig_d];
      for (int i = 0; i < 4; i++) begin
         dpLit_d[i] = ~dpSelNS[i] & ~flashOff;
      end
      signLit_d = ~flashOff;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dig_q      <= 3'd4;
         scan_q     <= SCAN_TOP;
         stbLeft_q  <= '0;
         stbW_q     <= '0;
         stbN_q     <= 1'b1;
         ovrBlank_q <= 1'b0;
         drive_q    <= '0;
         bcd_q      <= '0;
         dpLit_q    <= '0;
         signLit_q  <= 1'b0;
      end else begin
         dig_q      <= dig_d;
         scan_q     <= scan_d;
         stbLeft_q  <= stbLeft_d;
         stbW_q     <= stbW_d;
         stbN_q     <= stbN_d;
         ovrBlank_q <= ovrBlank_d;
         drive_q    <= drive_d;
         bcd_q      <= bcd_d;
         dpLit_q    <= dpLit_d;
         signLit_q  <= signLit_d;
      end
   end

   // one word per finished reading; space is checked before each start
   dss_fifo #(
      .WIDTH ($bits(dss_pkg::dss_reading_t)),
      .DEPTH (dss_pkg::FIFO_DEPTH)
   ) u_fifo (
      .refClk   (ref_clk),
      .arstN    (arst_n),
      .inValid  (push_q),
      .inReady  (fifoReady),
      .inData   (rd_q),
      .outValid (fifoValid),
      .outReady (readingReady),
      .outData  (fifoData)
   );

   assign signal_integrate_phase    = phase_q == dss_pkg::PH_SIG;
   assign reference_integrate_phase = phase_q == dss_pkg::PH_REF;
   assign auto_zero_phase           = phase_q == dss_pkg::PH_AZ || phase_q == dss_pkg::PH_HOLD;
   assign refNegative               = pol_q;   // reference opposes the signal
   assign convBusy                  = busy_q;
   assign over_range_flag           = ovr_q;
   assign polarity                  = pol_q;
   assign signLit                   = signLit_q;
   assign decimalPointLit           = dpLit_q;
   assign digit_drive               = drive_q;
   assign bcdDigit                  = bcd_q;
   assign strobeN                   = stbN_q;
   assign readingValid              = fifoValid;
   assign readingData               = fifoData;
endmodule

/* dv/dss_sequencer_assertions.sv */
`timescale 1ns/10ps
// pin-level checker for the sequencer
module dss_sequencer_assertions #(
   parameter int SIG_CNT      = 10000,
   parameter int AZ_START_CNT = 10001
) (
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  arst_n,
   // pins in
   input wire logic                  zeroCross,
   input wire logic                  holdRun,
   input wire logic                  blankingN,
   input wire logic [3:0]            decimalPointSelN,
   // phases and display
   input wire logic                  signal_integrate_phase,
   input wire logic                  reference_integrate_phase,
   input wire logic                  auto_zero_phase,
   input wire logic                  convBusy,
   input wire logic                  polarity,
   input wire logic [3:0]            decimalPointLit,
   input wire logic [4:0]            digit_drive,
   input wire logic                  strobeN,
   // stream
   input wire logic                  readingValid,
   input wire logic                  readingReady,
   input wire dss_pkg::dss_reading_t readingData
);
   int sigCnt_q;
   int lowCnt_q;
   int holdLow_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // run lengths; counters beat long repetitions for tool speed
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sigCnt_q <= 0;
         lowCnt_q <= 0;
         holdLow_q <= 0;
      end else begin
         sigCnt_q <= signal_integrate_phase ? sigCnt_q + 1 : 0;
         lowCnt_q <= strobeN ? 0 : lowCnt_q + 1;
         holdLow_q <= holdRun ? 0 : holdLow_q + 1;
      end
   end

   sequence sSigStart;
      $rose(signal_integrate_phase);
   endsequence
   sequence sSigEnd;
      $fell(signal_integrate_phase);
   endsequence

   a_busy_at_start: assert property (sSigStart |-> convBusy)
      else $error("busy not set at signal start");
   a_busy_after_cross: assert property (
      $rose(zeroCross) && reference_integrate_phase |-> ##[1:3] !convBusy)
      else $error("busy not cleared after crossing");
   a_sig_length: assert property (
      sSigEnd |-> sigCnt_q == SIG_CNT && reference_integrate_phase)
      else $error("signal integrate length wrong");
   a_phase_onehot: assert property (
      $onehot({signal_integrate_phase, reference_integrate_phase, auto_zero_phase}))
      else $error("phases not one-hot");
   // a start pulse may end up to one start auto-zero before signal integrate
   a_hold_blocks: assert property (
      auto_zero_phase && holdLow_q > AZ_START_CNT + 4 |=> !signal_integrate_phase)
      else $error("conversion started while held");
   a_strobe_width: assert property (
      $rose(strobeN) |-> lowCnt_q == dss_pkg::STROBE_CYC)
      else $error("strobe width wrong");
   a_strobe_digit: assert property (!strobeN |-> $onehot(digit_drive))
      else $error("strobe outside a digit period");
   a_blank_digits: assert property ((!blankingN)[*5] |-> digit_drive == 5'h00)
      else $error("digits not blanked");
   a_dp_follow: assert property (
      ($stable(decimalPointSelN))[*5] |-> decimalPointLit == ~decimalPointSelN)
      else $error("decimal points wrong");
   a_pol_change: assert property ($changed(polarity) |-> reference_integrate_phase)
      else $error("polarity changed outside reference integrate");
   a_stream_hold: assert property (
      readingValid && !readingReady |=> readingValid && $stable(readingData))
      else $error("reading changed while stalled");
endmodule

bind dss_sequencer dss_sequencer_assertions #(
   .SIG_CNT(SIG_CNT), .AZ_START_CNT(AZ_START_CNT)) i_chk (
   .ref_clk(ref_clk), .arst_n(arst_n), .zeroCross(zeroCross), .holdRun(holdRun),
   .blankingN(blankingN), .decimalPointSelN(decimalPointSelN),
   .signal_integrate_phase(signal_integrate_phase),
   .reference_integrate_phase(reference_integrate_phase),
   .auto_zero_phase(auto_zero_phase), .convBusy(convBusy), .polarity(polarity),
   .decimalPointLit(decimalPointLit), .digit_drive(digit_drive), .strobeN(strobeN),
   .readingValid(readingValid), .readingReady(readingReady), .readingData(readingData)
);

/* dv/dss_reader.sv */
`timescale 1ns/10ps
// far-side reader: strobe latches and a stream consumer that can stall
module dss_reader (
   // clock
   input  wire logic                  ref_clk,
   // display side
   input  wire logic                  strobeN,
   input  wire logic [4:0]            digit_drive,
   input  wire logic [3:0]            bcdDigit,
   // stream side
   input  wire logic                  readingValid,
   output logic                       readingReady,
   input  wire dss_pkg::dss_reading_t readingData,
   // test control and results
   input  wire logic                  stall,
   output logic [4:0][3:0]            latched,
   output int                         nStrobes,
   output int                         nPops,
   output dss_pkg::dss_reading_t      lastWord
);
   logic strobePrev;

   initial begin
      strobePrev = 1'b1;
      readingReady = 1'b0;
      latched = '0;
      nStrobes = 0;
      nPops = 0;
      lastWord = '0;
   end

   // latch the shown digit at each strobe, pop when not stalled
   always @(posedge ref_clk) begin
      if (strobePrev && !strobeN) begin
         nStrobes <= nStrobes + 1;
         for (int i = 0; i < 5; i++)
            if (digit_drive[i])
               latched[i] <= bcdDigit;
      end
      if (readingValid && readingReady) begin
         nPops <= nPops + 1;
         lastWord <= readingData;
      end
      strobePrev <= strobeN;
      readingReady <= !stall;
   end
endmodule

/* dv/tb_dual_slope_cycle_sequencer.sv */
`timescale 1ns/10ps
module tb_dual_slope_cycle_sequencer;
   localparam int CYC = 402;
   localparam int AZS = 101;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic zeroCross = 1'b0;
   logic signalPositive = 1'b1;
   logic holdRun = 1'b1;
   logic blankingN = 1'b1;
   logic [3:0] decimalPointSelN = 4'hf;
   logic stall = 1'b0;
   logic sigPh, refPh, azPh, refNeg, convBusy, ovr, polarity, signLit, strobeN, sigPrev;
   logic [3:0] dpLit, bcdDigit;
   logic [4:0] digit_drive;
   logic readingValid, readingReady;
   dss_pkg::dss_reading_t readingData, lastWord;
   logic [4:0][3:0] latched;
   int nStrobes, nPops;
   int fails = 0;
   int n_checks = 0;
   int refDelay = 37;
   int refCnt = 0;
   int sigRises = 0;
   int cyc = 0;
   int lastRise = 0;

   dss_sequencer #(.CYCLE_CNT(CYC), .SIG_CNT(100), .AZ_START_CNT(AZS)) i_dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .zeroCross(zeroCross),
      .signalPositive(signalPositive), .holdRun(holdRun), .blankingN(blankingN),
      .decimalPointSelN(decimalPointSelN), .signal_integrate_phase(sigPh),
      .reference_integrate_phase(refPh), .auto_zero_phase(azPh), .refNegative(refNeg),
      .convBusy(convBusy), .over_range_flag(ovr), .polarity(polarity), .signLit(signLit),
      .decimalPointLit(dpLit), .digit_drive(digit_drive), .bcdDigit(bcdDigit),
      .strobeN(strobeN), .readingValid(readingValid), .readingReady(readingReady),
      .readingData(readingData));

   dss_reader i_reader (
      .ref_clk(ref_clk), .strobeN(strobeN), .digit_drive(digit_drive),
      .bcdDigit(bcdDigit), .readingValid(readingValid), .readingReady(readingReady),
      .readingData(readingData), .stall(stall), .latched(latched),
      .nStrobes(nStrobes), .nPops(nPops), .lastWord(lastWord));

   always #50 ref_clk = ~ref_clk;

   // comparator trips refDelay clocks into reference integrate
   always @(negedge ref_clk) begin
      refCnt = refPh ? refCnt + 1 : 0;
      zeroCross = (refCnt > refDelay);
   end

   // count cycles and signal integrate starts
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      sigPrev <= sigPh;
      if (sigPh && !sigPrev) begin
         sigRises <= sigRises + 1;
         lastRise <= cyc;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic waitRise();
      int k;
      k = sigRises + 1;
      for (int i = 0; i < 3 * CYC && sigRises < k; i++)
         @(negedge ref_clk);
      check(sigRises >= k, 1'b1);
   endtask

   // reading in counts; crossing is seen two or three clocks late
   task automatic checkReading(input logic pos);
      int v;
      v = 0;
      for (int i = 4; i >= 0; i--)
         v = v * 10 + lastWord.digits[i];
      check(v inside {[refDelay:refDelay + 5]}, 1'b1);
      check(lastWord.positive, pos);
      check(polarity, pos);
      check(lastWord.overRange, 1'b0);
   endtask

   task automatic tFreeRun();
      int t0;
      waitRise();
      check(convBusy, 1'b1);
      t0 = lastRise;
      waitRise();
      check(lastRise - t0, CYC);
      checkReading(1'b1);
      check(refNeg, 1'b1);
      check(ovr, 1'b0);
   endtask

   // hold mid-cycle, short and long start pulses, then an early pulse
   task automatic tHold();
      int s0, n0;
      signalPositive = 1'b0;
      refDelay = 60;
      waitRise();
      holdRun = 1'b0;
      s0 = sigRises;
      // earlier strobes restart at each free-run end; count only the held reading's
      repeat (CYC - 1) @(negedge ref_clk);
      n0 = nStrobes;
      repeat (100) @(negedge ref_clk);
      check(strobeN, 1'b1);
      @(negedge ref_clk);
      check(strobeN, 1'b0);
      repeat (1400) @(negedge ref_clk);
      check(sigRises - s0, 0);
      check(nStrobes - n0, 5);
      check(latched, lastWord.digits);
      checkReading(1'b0);
      holdRun = 1'b1;
      repeat (2) @(negedge ref_clk);
      holdRun = 1'b0;
      repeat (300) @(negedge ref_clk);
      check(sigRises - s0, 0);
      s0 = cyc;
      holdRun = 1'b1;
      repeat (4) @(negedge ref_clk);
      holdRun = 1'b0;
      waitRise();
      check((lastRise - s0) inside {[AZS:AZS + 6]}, 1'b1);
      holdRun = 1'b1;
      repeat (5) @(negedge ref_clk);
      holdRun = 1'b0;
      s0 = sigRises;
      repeat (1200) @(negedge ref_clk);
      check(sigRises - s0, 0);
   endtask

   task automatic tDisplay();
      blankingN = 1'b0;
      repeat (10) @(negedge ref_clk);
      check(digit_drive, 5'h00);
      check(signLit, 1'b1);
      blankingN = 1'b1;
      for (int i = 0; i < 4; i++) begin
         decimalPointSelN = ~(4'h1 << i);
         repeat (5) @(negedge ref_clk);
         check(dpLit, 4'h1 << i);
      end
      decimalPointSelN = 4'hf;
   endtask

   // stall the reader until the buffer refuses, then drain it
   task automatic tFifo();
      int p0, r0;
      stall = 1'b1;
      holdRun = 1'b1;
      p0 = nPops;
      repeat (34 * CYC) @(negedge ref_clk);
      r0 = sigRises;
      repeat (1000) @(negedge ref_clk);
      check(sigRises - r0, 0);
      check(readingValid, 1'b1);
      stall = 1'b0;
      repeat (100) @(negedge ref_clk);
      check(nPops - p0, dss_pkg::FIFO_DEPTH);
      check(readingValid, 1'b0);
   endtask

   task automatic conclude();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog well beyond the expected run
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      conclude();
   end

   initial begin
      repeat (5) @(negedge ref_clk);
      arst_n = 1'b1;
      tFreeRun();
      tHold();
      tDisplay();
      tFifo();
      conclude();
   end
endmodule
